// ---- rtl/hall_i2c_pkg.sv ----
// Purpose: shared constants and types for the hall sensor bus target logic
// Assumes: one clock, synchronous active-high reset
// Notes:   the mode register copy mirrors the byte written at its map address
package hall_i2c_pkg;

	// 7-bit bus addresses chosen by the two address-select bits
	localparam logic [6:0] ADDR_DEFAULT = 7'h35;
	localparam logic [6:0] ADDR_ALT1    = 7'h1a;
	localparam logic [6:0] ADDR_ALT2    = 7'h2a;
	localparam logic [6:0] ADDR_ALT3    = 7'h3a;
	localparam logic [1:0] ADDR_SEL_DEFAULT = 2'h0;

	// register map
	localparam logic [4:0] REG_FIRST     = 5'h00;
	localparam logic [4:0] REG_LAST      = 5'h16;
	localparam logic [4:0] REG_MODE      = 5'h11;
	localparam logic [4:0] REG_TRIG_LAST = 5'h05;
	localparam logic [7:0] MODE_RESET    = 8'h00;
	localparam logic [7:0] IDLE_BYTE     = 8'hff;

	// operating mode encodings
	localparam logic [1:0] OP_MASTER_CTRL = 2'h1;

	// trigger field encodings
	localparam logic [2:0] TRIG_NONE   = 3'h0;
	localparam logic [2:0] TRIG_001    = 3'h1;
	localparam logic [2:0] TRIG_010    = 3'h2;
	localparam logic [2:0] TRIG_011    = 3'h3;
	localparam logic [2:0] TRIG_100    = 3'h4;
	localparam logic [2:0] TRIG_101    = 3'h5;
	localparam logic [2:0] TRIG_110    = 3'h6;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef struct packed {
		logic       mode_parity_bit;
		logic [1:0] bus_address_select;
		logic       read_protocol_select;
		logic       collision_avoid_ctrl;
		logic       int_disable;
		logic [1:0] op_mode;
	} mode_reg_type;

	typedef enum logic [9:0] {
		ST_IDLE     = 10'h001,
		ST_ADDR     = 10'h002,
		ST_ADDR_ACK = 10'h004,
		ST_CMD      = 10'h008,
		ST_CMD_ACK  = 10'h010,
		ST_WDATA    = 10'h020,
		ST_WACK     = 10'h040,
		ST_RDATA    = 10'h080,
		ST_RACK     = 10'h100,
		ST_IGNORE   = 10'h200
	} fsm_type;

	typedef struct packed {
		fsm_type      fsm;
		logic         scl_q;
		logic         sda_q;
		logic [3:0]   cnt;
		logic [7:0]   shreg;
		logic         rd;
		logic [2:0]   trig;
		logic [4:0]   ptr;
		logic         sda_oe;
		logic         sda_out;
		logic         reg_we;
		logic [7:0]   wdata;
		logic         adc_start;
		logic         wr_trig;
		mode_reg_type mode;
		logic         parity_ok;
	} target_state_type;

endpackage

// ---- rtl/hall_i2c_target.sv ----
// Purpose: bus target protocol logic of a 3d hall sensor with adc trigger decode
// Assumes: scl and sda inputs are synchronous to mclk; register storage lies outside
// Notes:   only the mode register is mirrored here, since it steers the protocol
//
// Notes on behaviour
// - adc trigger bits act only in power-down of controller-driven mode.
// - write frame codes 001, 011, 101 start conversion after the stop.
// - write frame codes 000, 010, 100, 110 never start a conversion.
// - 2-byte read codes 010, 011 start conversion before first data msb.
// - read codes 100, 101, 110 start conversion after register 05 is sent.
// - default address bytes are 6a write, 6b read; answer own address only.
// - acknowledge low after the address and each received byte without error.
// - mode parity bit is odd parity over register 11 and register 13 bits 7:5.
// - address-select field 00 keeps the default address pair.
// - read-protocol bit 0 keeps the 2-byte read protocol.
// - collision-avoid 0 with interrupt bit 1 selects clock stretching, no interrupt; here both bits are only kept in mode_cfg, scl is never held low.
// - operating-mode field 01 selects controller-driven measurement mode.
// - in 2-byte reads the second byte's address picks the first register.
// - 1-byte reads send data right after address ack, from register 00.
// - writing register 11 with bit 4 set enables the 1-byte read protocol.
// - each further read byte advances the register address by one.
// - reads past the last register leave the data line released high.
// - a not-acknowledge from the controller releases data until the stop.
// - repeated start is unsupported; each addressing follows a stop.
// - write bytes past the map are dropped and answered high.
// - all bytes shift msb first.
`timescale 1ns/100ps

module hall_i2c_target (
	input  wire logic                        mclk,
	input  wire logic                        rst,
	input  wire logic                        scl,
	input  wire logic                        sda_in,
	input  wire logic                        adc_busy,
	input  wire logic [2:0]                  reg13_hi,
	input  wire logic [7:0]                  reg_rdata,
	output logic                             sda_out,
	output logic                             sda_oe,
	output logic [4:0]                       reg_addr,
	output logic [7:0]                       reg_wdata,
	output logic                             reg_we,
	output logic                             adc_start,
	output hall_i2c_pkg::mode_reg_type       mode_cfg,
	output logic                             mode_parity_ok
);
	import hall_i2c_pkg::*;

	target_state_type s;
	target_state_type next_s;

	function automatic logic [6:0] dev_addr(input logic [1:0] sel);
		case (sel)
			ADDR_SEL_DEFAULT: dev_addr = ADDR_DEFAULT;
			2'h1:             dev_addr = ADDR_ALT1;
			2'h2:             dev_addr = ADDR_ALT2;
			default:          dev_addr = ADDR_ALT3;
		endcase
	endfunction

	function automatic logic in_map(input logic [4:0] a);
		in_map = (a >= REG_FIRST) && (a <= REG_LAST);
	endfunction

	// bytes past the map read as all ones so the line stays released
	function automatic logic [7:0] tx_byte(input logic [4:0] a, input logic [7:0] d);
		tx_byte = in_map(a) ? d : IDLE_BYTE;
	endfunction

	function automatic logic write_trigger(input logic [2:0] t);
		write_trigger = (t == TRIG_001) || (t == TRIG_011) || (t == TRIG_101);
	endfunction

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic power_down;
	logic [7:0] shifted;
	logic [7:0] load;

	always_comb
	begin
		scl_rise   = scl & ~s.scl_q;
		scl_fall   = ~scl & s.scl_q;
		bus_start  = scl & s.scl_q & s.sda_q & ~sda_in;
		bus_stop   = scl & s.scl_q & ~s.sda_q & sda_in;
		power_down = (s.mode.op_mode == OP_MASTER_CTRL) && !adc_busy;
		shifted    = {s.shreg[6:0], sda_in};
		load       = tx_byte(s.ptr, reg_rdata);

		next_s           = s;
		next_s.scl_q     = scl;
		next_s.sda_q     = sda_in;
		next_s.reg_we    = 1'b0;
		next_s.adc_start = 1'b0;
		next_s.sda_out   = 1'b0;

		if (bus_stop)
		begin
			// the write trigger waits for the whole frame so the new settings apply
			if (s.fsm != ST_IDLE && s.wr_trig && power_down)
			begin
				next_s.adc_start = 1'b1;
			end
			next_s.fsm     = ST_IDLE;
			next_s.sda_oe  = 1'b0;
			next_s.wr_trig = 1'b0;
		end
		else if (bus_start)
		begin
			if (s.fsm == ST_IDLE)
			begin
				next_s.fsm  = ST_ADDR;
				next_s.cnt  = 4'h0;
				next_s.trig = TRIG_NONE;
			end
			else
			begin
				// a repeated start is not decoded; wait for the stop
				next_s.fsm    = ST_IGNORE;
				next_s.sda_oe = 1'b0;
			end
		end
		else
		begin
			case (s.fsm)
				ST_IDLE:
				begin
					next_s.sda_oe = 1'b0;
				end
				ST_ADDR:
				begin
					if (scl_rise)
					begin
						next_s.shreg = shifted;
						next_s.cnt   = s.cnt + 4'h1;
					end
					else if (scl_fall && s.cnt == BITS_PER_BYTE)
					begin
						if (s.shreg[7:1] == dev_addr(s.mode.bus_address_select))
						begin
							next_s.rd     = s.shreg[0];
							next_s.ptr    = REG_FIRST;
							next_s.sda_oe = 1'b1;
							next_s.fsm    = ST_ADDR_ACK;
						end
						else
						begin
							next_s.fsm = ST_IGNORE;
						end
					end
				end
				ST_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						next_s.cnt = 4'h0;
						if (s.rd && s.mode.read_protocol_select)
						begin
							next_s.shreg  = load;
							next_s.sda_oe = ~load[7];
							next_s.fsm    = ST_RDATA;
						end
						else
						begin
							next_s.sda_oe = 1'b0;
							next_s.fsm    = ST_CMD;
						end
					end
				end
				ST_CMD:
				begin
					if (scl_rise)
					begin
						next_s.shreg = shifted;
						next_s.cnt   = s.cnt + 4'h1;
					end
					else if (scl_fall && s.cnt == BITS_PER_BYTE)
					begin
						next_s.trig    = s.shreg[7:5];
						next_s.ptr     = s.shreg[4:0];
						next_s.wr_trig = !s.rd && write_trigger(s.shreg[7:5]);
						next_s.sda_oe  = 1'b1;
						next_s.fsm     = ST_CMD_ACK;
					end
				end
				ST_CMD_ACK:
				begin
					if (scl_fall)
					begin
						next_s.cnt = 4'h0;
						if (s.rd)
						begin
							if ((s.trig == TRIG_010 || s.trig == TRIG_011) && power_down)
							begin
								next_s.adc_start = 1'b1;
							end
							next_s.shreg  = load;
							next_s.sda_oe = ~load[7];
							next_s.fsm    = ST_RDATA;
						end
						else
						begin
							next_s.sda_oe = 1'b0;
							next_s.fsm    = ST_WDATA;
						end
					end
				end
				ST_WDATA:
				begin
					if (scl_rise)
					begin
						next_s.shreg = shifted;
						next_s.cnt   = s.cnt + 4'h1;
					end
					else if (scl_fall && s.cnt == BITS_PER_BYTE)
					begin
						if (in_map(s.ptr))
						begin
							next_s.reg_we = 1'b1;
							next_s.wdata  = s.shreg;
							next_s.sda_oe = 1'b1;
							next_s.ptr    = s.ptr + 5'h1;
							if (s.ptr == REG_MODE)
							begin
								next_s.mode = mode_reg_type'(s.shreg);
							end
						end
						else
						begin
							next_s.sda_oe = 1'b0;
						end
						next_s.fsm = ST_WACK;
					end
				end
				ST_WACK:
				begin
					if (scl_fall)
					begin
						next_s.sda_oe = 1'b0;
						next_s.cnt    = 4'h0;
						next_s.fsm    = ST_WDATA;
					end
				end
				ST_RDATA:
				begin
					if (scl_rise)
					begin
						next_s.cnt = s.cnt + 4'h1;
					end
					else if (scl_fall)
					begin
						if (s.cnt == BITS_PER_BYTE)
						begin
							next_s.sda_oe = 1'b0;
							next_s.fsm    = ST_RACK;
						end
						else
						begin
							next_s.shreg  = {s.shreg[6:0], 1'b1};
							next_s.sda_oe = ~s.shreg[6];
						end
					end
				end
				ST_RACK:
				begin
					if (scl_rise)
					begin
						if (sda_in)
						begin
							next_s.fsm = ST_IGNORE;
						end
						else
						begin
							if (s.ptr == REG_TRIG_LAST && power_down &&
								(s.trig == TRIG_100 || s.trig == TRIG_101 || s.trig == TRIG_110))
							begin
								next_s.adc_start = 1'b1;
							end
							// past the map the pointer parks so it cannot wrap to 00
							if (in_map(s.ptr))
							begin
								next_s.ptr = s.ptr + 5'h1;
							end
						end
					end
					else if (scl_fall)
					begin
						next_s.cnt    = 4'h0;
						next_s.shreg  = load;
						next_s.sda_oe = ~load[7];
						next_s.fsm    = ST_RDATA;
					end
				end
				ST_IGNORE:
				begin
					next_s.sda_oe = 1'b0;
				end
				default:
				begin
					next_s.fsm    = ST_IDLE;
					next_s.sda_oe = 1'b0;
				end
			endcase
		end

		// odd parity: the xor over the covered bits must come out as one
		next_s.parity_ok = ^{next_s.mode, reg13_hi};
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s           <= '0;
			s.fsm       <= ST_IDLE;
			s.scl_q     <= 1'b1;
			s.sda_q     <= 1'b1;
			s.shreg     <= IDLE_BYTE;
			s.ptr       <= REG_FIRST;
			s.mode      <= mode_reg_type'(MODE_RESET);
		end
		else
		begin
			s <= next_s;
		end
	end

	assign sda_out        = s.sda_out;
	assign sda_oe         = s.sda_oe;
	assign reg_addr       = s.ptr;
	assign reg_wdata      = s.wdata;
	assign reg_we         = s.reg_we;
	assign adc_start      = s.adc_start;
	assign mode_cfg       = s.mode;
	assign mode_parity_ok = s.parity_ok;

endmodule

// ---- verif/bus_ctrl_model.sv ----
// Purpose: bus controller model driving scl and sda toward the target
// Assumes: sda has a pull-up; the wire level returns on sda
// Notes:   each data bit's scl phase lasts two or three mclk, the shortest the target takes
`timescale 1ns/100ps
module bus_ctrl_model (
	input  wire logic mclk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_drv
);
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// data changes only while scl is low, so no false start or stop
	task automatic bt(input logic b, output logic r);
		sda_drv <= b;
		tk(2);
		scl <= 1'b1;
		tk(2);
		r = sda;
		scl <= 1'b0;
		tk(1);
	endtask
	// msb first; reads pass ff so the line stays released
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--)
			bt(d[i], q[i]);
		bt(a, k);
	endtask
	// called mid-frame this makes the repeated start the target must ignore
	task automatic start();
		sda_drv <= 1'b1;
		tk(2);
		scl <= 1'b1;
		tk(2);
		sda_drv <= 1'b0;
		tk(2);
		scl <= 1'b0;
		tk(1);
	endtask
	task automatic stop();
		sda_drv <= 1'b0;
		tk(2);
		scl <= 1'b1;
		tk(2);
		sda_drv <= 1'b1;
		tk(4);
	endtask
endmodule

// ---- verif/hall_i2c_target_props.sv ----
// Purpose: port-level properties of the hall sensor bus target
// Assumes: one clock domain, synchronous active-high reset
// Notes:   byte contents are judged by the bench; timing relations live here
`timescale 1ns/100ps
module hall_i2c_target_props (
	input wire logic                       mclk,
	input wire logic                       rst,
	input wire logic                       scl,
	input wire logic                       adc_busy,
	input wire logic [2:0]                 reg13_hi,
	input wire logic                       sda_out,
	input wire logic                       sda_oe,
	input wire logic [4:0]                 reg_addr,
	input wire logic [7:0]                 reg_wdata,
	input wire logic                       reg_we,
	input wire logic                       adc_start,
	input wire hall_i2c_pkg::mode_reg_type mode_cfg,
	input wire logic                       mode_parity_ok
);
	import hall_i2c_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_drive_low; sda_out == 1'b0; endproperty
	a_drive_low: assert property (p_drive_low) else $error("sda driven high");
	property p_hold_high; scl && $past(scl) |-> $stable(sda_oe); endproperty
	a_hold_high: assert property (p_hold_high) else $error("sda moved while scl high");
	// a change is allowed only in the first cycles after a falling scl
	property p_move_late; $changed(sda_oe) |-> !scl && ($past(scl, 2) || $past(scl, 3)); endproperty
	a_move_late: assert property (p_move_late) else $error("sda moved away from scl fall");
	property p_start_pulse; adc_start |=> !adc_start; endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
	property p_start_gate; adc_start |-> mode_cfg.op_mode == OP_MASTER_CTRL && !$past(adc_busy); endproperty
	a_start_gate: assert property (p_start_gate) else $error("start outside power-down");
	property p_we_step; reg_we |-> reg_addr == $past(reg_addr) + 5'h1 ##1 !reg_we; endproperty
	a_we_step: assert property (p_we_step) else $error("pointer not stepped on write");
	property p_we_range; reg_we |-> reg_addr - 5'h1 <= REG_LAST; endproperty
	a_we_range: assert property (p_we_range) else $error("write past map");
	property p_mode_src; $changed(mode_cfg) |-> reg_we && reg_addr == REG_MODE + 5'h1; endproperty
	a_mode_src: assert property (p_mode_src) else $error("mode changed without write");
	property p_mode_val; reg_we && reg_addr == REG_MODE + 5'h1 |-> mode_cfg == reg_wdata; endproperty
	a_mode_val: assert property (p_mode_val) else $error("mode copy differs");
	property p_parity; !$past(rst) && $stable(mode_cfg) && $stable(reg13_hi) |-> mode_parity_ok == ^{mode_cfg, reg13_hi}; endproperty
	a_parity: assert property (p_parity) else $error("parity flag wrong");
endmodule
bind hall_i2c_target hall_i2c_target_props u_props (.mclk(mclk), .rst(rst), .scl(scl), .adc_busy(adc_busy),
	.reg13_hi(reg13_hi), .sda_out(sda_out), .sda_oe(sda_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_we(reg_we), .adc_start(adc_start), .mode_cfg(mode_cfg), .mode_parity_ok(mode_parity_ok));

// ---- verif/test_hall_i2c_target.sv ----
// Purpose: frame-level tests of the hall sensor bus target
// Assumes: register storage answers {3'h5, address}
// Notes:   conversion starts are counted per frame, not timed
`timescale 1ns/100ps
module test_hall_i2c_target;
	import hall_i2c_pkg::*;
	logic                 mclk = 1'b0;
	logic                 rst = 1'b1;
	logic                 adc_busy = 1'b0;
	logic [2:0]           reg13_hi = 3'h0;
	logic                 scl, sda_drv, sda_out, sda_oe, reg_we, adc_start, mode_parity_ok, a;
	logic [4:0]           reg_addr, wa;
	logic [7:0]           reg_wdata, q, wd;
	mode_reg_type         mode_cfg;
	int                   n_fail, comparisons, n_st, n0, n_we;
	wire logic            sda = sda_drv & ~sda_oe;
	wire logic [7:0]      reg_rdata = {3'h5, reg_addr};
	always #5 mclk = ~mclk;
	always @(posedge mclk)
		if (adc_start === 1'b1)
			n_st++;
	// reg_addr has already stepped when the write strobe shows, so the target is one below
	always @(posedge mclk)
		if (reg_we === 1'b1)
		begin
			n_we++;
			wa <= reg_addr - 5'h1;
			wd <= reg_wdata;
		end
	hall_i2c_target dut (.mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda), .adc_busy(adc_busy),
		.reg13_hi(reg13_hi), .reg_rdata(reg_rdata), .sda_out(sda_out), .sda_oe(sda_oe), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .adc_start(adc_start), .mode_cfg(mode_cfg),
		.mode_parity_ok(mode_parity_ok));
	bus_ctrl_model ctl (.mclk(mclk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
	task wrap_up();
		$display("fails %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task chk_bit(input logic g, input logic e);
		chk({7'h0, g}, {7'h0, e});
	endtask
	function automatic logic [7:0] ex(input logic [5:0] p);
		ex = p <= REG_LAST ? {3'h5, p[4:0]} : IDLE_BYTE;
	endfunction
	task automatic wr(input logic [7:0] c, input logic [7:0] d, input int n, input logic ea);
		ctl.start();
		ctl.xfer(8'h6a, 1'b1, q, a);
		chk_bit(a, 1'b0);
		ctl.xfer(c, 1'b1, q, a);
		chk_bit(a, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			ctl.xfer(d, 1'b1, q, a);
			chk_bit(a, i == n - 1 ? ea : 1'b0);
		end
		ctl.stop();
	endtask
	task automatic rd(input logic cm, input logic [7:0] c, input int n, input int k);
		ctl.start();
		ctl.xfer(8'h6b, 1'b1, q, a);
		chk_bit(a, 1'b0);
		if (cm)
		begin
			ctl.xfer(c, 1'b1, q, a);
			chk_bit(a, 1'b0);
		end
		for (int i = 0; i < n; i++)
		begin
			ctl.xfer(8'hff, i >= k - 1, q, a);
			chk(q, i >= k ? IDLE_BYTE : ex(6'(c[4:0] + i)));
		end
		ctl.stop();
	endtask
	initial
	begin
		#500000;
		n_fail++;
		wrap_up();
	end
	initial
	begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		chk(mode_cfg, MODE_RESET);
		ctl.start();
		ctl.xfer(8'h6c, 1'b1, q, a);
		chk_bit(a, 1'b1);
		ctl.stop();
		wr(8'h11, 8'h85, 1, 1'b0);
		chk(mode_cfg, 8'h85);
		chk({3'h0, wa}, {3'h0, REG_MODE});
		chk(wd, 8'h85);
		chk_bit(mode_parity_ok, 1'b1);
		reg13_hi <= 3'h1;
		ctl.tk(3);
		chk_bit(mode_parity_ok, 1'b0);
		reg13_hi <= 3'h0;
		// trigger codes 000 to 110 in both directions
		for (int t = 0; t < 7; t++)
		begin
			n0 = n_st;
			wr({t[2:0], 5'h10}, 8'h3c, 1, 1'b0);
			chk_bit(n_st != n0, t[0]);
			n0 = n_st;
			rd(1'b1, {t[2:0], 5'h04}, 3, 3);
			chk_bit(n_st != n0, t >= 2);
		end
		chk(mode_cfg, 8'h85);
		rd(1'b1, 8'h15, 4, 4);
		rd(1'b1, 8'h02, 3, 1);
		n0 = n_we;
		wr(8'h16, 8'h5a, 2, 1'b1);
		chk_bit(n_we == n0 + 1, 1'b1);
		chk({3'h0, wa}, {3'h0, REG_LAST});
		chk(wd, 8'h5a);
		adc_busy <= 1'b1;
		n0 = n_st;
		wr(8'h30, 8'h3c, 1, 1'b0);
		chk_bit(n_st != n0, 1'b0);
		adc_busy <= 1'b0;
		wr(8'h11, 8'h86, 1, 1'b0);
		wr(8'h30, 8'h3c, 1, 1'b0);
		chk_bit(n_st != n0, 1'b0);
		ctl.start();
		ctl.xfer(8'h6a, 1'b1, q, a);
		ctl.start();
		ctl.xfer(8'h6a, 1'b1, q, a);
		chk_bit(a, 1'b1);
		ctl.stop();
		wr(8'h11, 8'h15, 1, 1'b0);
		rd(1'b0, 8'h00, 2, 2);
		// reset held long enough that the mode drop is never seen with reset already gone
		rst <= 1'b1;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		chk(mode_cfg, MODE_RESET);
		rd(1'b1, 8'h03, 1, 1);
		wrap_up();
	end
endmodule
